// ### atc_defs.svh
// Register map, field positions and constants of the 16-bit timer/counter
// Contract
// - With sync disable set, external edges advance the count without the extra sync stage.
// - Asynchronous counter mode keeps counting while the processor sleeps.
// - Asynchronous counter mode withdraws the count as capture/compare time base.
// - Reading either count byte always returns a clean, valid value.
// - Oscillator enable starts the crystal oscillator; it keeps running in sleep.
// - Asynchronous mode advances per clock or prescale multiple; overflow flags and wakes.
// - Compare mode code 1011 special event trigger resets the 16-bit count.
// - Special event reset of the count never sets the overflow flag.
// - Count write and special event in one cycle: the write wins.
// - With special event active, compare value pair acts as counter period.
// - Count bytes survive every reset; only writes, rollover or special event clear them.
// - Control register clears to zero on power-on reset, else keeps value; the code clears it on every aresetn reset.
// - A write to either count byte with write strobe bit 0 set clears the prescaler.
// - Control layout: prescale 5:4, osc enable 3, sync disable 2, source 1, on 0.
// - Prescale codes 00, 01, 10, 11 divide by 1, 2, 4, 8.
// - Source 1 counts external rising edges; source 0 counts Fosc/4.
// - Counter on enables counting; off holds the current count.
// - Count runs 0000h to FFFFh, rolls to 0000h and latches overflow.
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

`define ATC_OFF_CNT_LO 32'h0000_0000
`define ATC_OFF_CNT_HI 32'h0000_0004
`define ATC_OFF_CTRL 32'h0000_0008
`define ATC_OFF_IRQ 32'h0000_000c

`define ATC_CTL_ON 0
`define ATC_CTL_CS 1
`define ATC_CTL_SYNCD 2
`define ATC_CTL_OSCEN 3
`define ATC_CTL_PS_LO 4
`define ATC_CTL_PS_HI 5
`define ATC_CTL_RESET 6'h00

`define ATC_IRQ_FLAG 0
`define ATC_IRQ_EN 1

`define ATC_SPECIAL_MODE 4'hb
`define ATC_PHASE_LAST 2'h3
`define ATC_COUNT_MAX 16'hffff
`define ATC_COUNT_ZERO 16'h0000
`define ATC_RESP_OKAY 2'h0
`define ATC_RESP_SLVERR 2'h2

`endif

// ### atc_pkg.sv
// Types shared by the timer/counter modules
package atc_pkg;

  typedef struct packed {
    logic [2:0] cnt;
  } atc_presc_state_t;

  typedef struct packed {
    logic [5:0] control;
    logic [15:0] count;
    logic ovf_flag;
    logic ovf_ie;
    logic ovf_irq;
    logic timebase_valid;
    logic osc_amp;
    logic osc_amp_en;
    logic pin_prev;
    logic sync_stage;
    logic [1:0] int_phase;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [31:0] aw_addr;
    logic [7:0] wdata;
    logic wstrb0;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } atc_state_t;

endpackage

// ### atc_prescaler.sv
// Input prescaler: passes one of every 1, 2, 4 or 8 input edges
`timescale 1ns/1ns
`include "atc_defs.svh"
module atc_prescaler
  import atc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic edge_in,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic tick
);

  atc_presc_state_t s_reg;
  atc_presc_state_t s_next;
  logic [2:0] mask;

  always_comb begin
    unique case (sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
  end

  assign tick = edge_in && !clear && ((s_reg.cnt & mask) == mask);

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.cnt = 3'h0;
    end else if (edge_in) begin
      s_next.cnt = (s_reg.cnt & mask) == mask ? 3'h0 : s_reg.cnt + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ### atc_timer.sv
// 16-bit timer/counter with AXI4-Lite register access
`timescale 1ns/1ns
`include "atc_defs.svh"
module atc_timer
  import atc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_pin,
  input wire logic osc_input_pin,
  output logic osc_output_pin,
  output logic osc_output_en_n,
  input wire logic sleep_mode,
  input wire logic [3:0] compare_mode_code,
  input wire logic [15:0] compare_value_pair,
  output logic [15:0] timebase_count,
  output logic timebase_valid,
  output logic overflow_irq
);

  atc_state_t s_reg;
  atc_state_t s_next;

  logic counter_on;
  logic clock_source_select;
  logic sync_disable;
  logic oscillator_enable;
  logic async_mode;
  logic ext_src;
  logic ext_rise;
  logic int_edge;
  logic presc_in;
  logic presc_tick;
  logic do_write;
  logic wr_lo;
  logic wr_hi;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_ok;
  logic inc;
  logic special_reset;
  logic ovf_event;
  logic ar_hs;
  logic [31:0] rd_word;
  logic rd_ok;

  assign counter_on = s_reg.control[`ATC_CTL_ON];
  assign clock_source_select = s_reg.control[`ATC_CTL_CS];
  assign sync_disable = s_reg.control[`ATC_CTL_SYNCD];
  assign oscillator_enable = s_reg.control[`ATC_CTL_OSCEN];
  assign async_mode = clock_source_select && sync_disable;

  // External source is the crystal input when the oscillator runs
  assign ext_src = oscillator_enable ? osc_input_pin : ext_clock_pin;
  assign ext_rise = ext_src && !s_reg.pin_prev;
  // Fosc/4 stops while the core sleeps
  assign int_edge = (s_reg.int_phase == `ATC_PHASE_LAST) && !sleep_mode;
  assign presc_in = counter_on && (clock_source_select ? ext_rise : int_edge);

  // Register write happens once address and data are both held
  assign do_write = !s_reg.awready && !s_reg.wready && !s_reg.bvalid;
  assign wr_lo = do_write && s_reg.wstrb0 && (s_reg.aw_addr == `ATC_OFF_CNT_LO);
  assign wr_hi = do_write && s_reg.wstrb0 && (s_reg.aw_addr == `ATC_OFF_CNT_HI);
  assign wr_ctrl = do_write && s_reg.wstrb0 && (s_reg.aw_addr == `ATC_OFF_CTRL);
  assign wr_irq = do_write && s_reg.wstrb0 && (s_reg.aw_addr == `ATC_OFF_IRQ);
  assign wr_ok = (s_reg.aw_addr == `ATC_OFF_CNT_LO) || (s_reg.aw_addr == `ATC_OFF_CNT_HI) ||
                 (s_reg.aw_addr == `ATC_OFF_CTRL) || (s_reg.aw_addr == `ATC_OFF_IRQ);

  atc_prescaler u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .edge_in(presc_in),
    .clear(wr_lo || wr_hi),
    .sel(s_reg.control[`ATC_CTL_PS_HI:`ATC_CTL_PS_LO]),
    .tick(presc_tick)
  );

  // Asynchronous mode and Fosc/4 take the prescaler output straight; the synchronized
  // external path goes through one sync stage whose output is ignored while the core sleeps
  always_comb begin
    if (clock_source_select && sync_disable) begin
      inc = counter_on && presc_tick;
    end else if (clock_source_select) begin
      inc = counter_on && s_reg.sync_stage && !sleep_mode;
    end else begin
      inc = counter_on && presc_tick;
    end
  end

  // Compare value pair acts as period while the special event is selected
  assign special_reset = (compare_mode_code == `ATC_SPECIAL_MODE) &&
                         (s_reg.count == compare_value_pair);
  assign ovf_event = inc && !special_reset && !wr_lo && !wr_hi &&
                     (s_reg.count == `ATC_COUNT_MAX);

  assign ar_hs = s_axi_arvalid && s_reg.arready;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `ATC_OFF_CNT_LO: rd_word[7:0] = s_reg.count[7:0];
      `ATC_OFF_CNT_HI: rd_word[7:0] = s_reg.count[15:8];
      `ATC_OFF_CTRL: rd_word[5:0] = s_reg.control;
      `ATC_OFF_IRQ: begin
        rd_word[`ATC_IRQ_FLAG] = s_reg.ovf_flag;
        rd_word[`ATC_IRQ_EN] = s_reg.ovf_ie;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.pin_prev = ext_src;
    s_next.int_phase = s_reg.int_phase + 2'h1;
    s_next.sync_stage = presc_tick && !sync_disable;

    // Count: a write beats the special event, which beats an increment
    if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        s_next.count[7:0] = s_reg.wdata;
      end
      if (wr_hi) begin
        s_next.count[15:8] = s_reg.wdata;
      end
    end else if (special_reset) begin
      s_next.count = `ATC_COUNT_ZERO;
    end else if (inc) begin
      s_next.count = s_reg.count + 16'h0001;
    end

    if (wr_ctrl) begin
      s_next.control = s_reg.wdata[5:0];
    end
    if (wr_irq) begin
      s_next.ovf_ie = s_reg.wdata[`ATC_IRQ_EN];
      if (s_reg.wdata[`ATC_IRQ_FLAG]) begin
        s_next.ovf_flag = 1'b0;
      end
    end
    // Hardware set wins over a clear in the same cycle
    if (ovf_event) begin
      s_next.ovf_flag = 1'b1;
    end
    s_next.ovf_irq = s_next.ovf_flag && s_next.ovf_ie;
    s_next.timebase_valid = !(s_next.control[`ATC_CTL_CS] &&
                              s_next.control[`ATC_CTL_SYNCD]);
    // Oscillator amplifier runs regardless of sleep
    s_next.osc_amp_en = s_next.control[`ATC_CTL_OSCEN];
    s_next.osc_amp = !osc_input_pin;

    // Write channel
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awready = 1'b0;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wready = 1'b0;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wstrb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_ok ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    // Read channel
    if (ar_hs) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = rd_ok ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // Reset clears everything except the count bytes; the ready flags and timebase_valid come up set
    if (!aresetn) begin
      s_next = '0;
      s_next.count = s_reg.count;
      s_next.control = `ATC_CTL_RESET;
      s_next.timebase_valid = 1'b1;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_reg <= s_next;
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign osc_output_pin = s_reg.osc_amp;
  assign osc_output_en_n = !s_reg.osc_amp_en;
  assign timebase_count = s_reg.count;
  assign timebase_valid = s_reg.timebase_valid;
  assign overflow_irq = s_reg.ovf_irq;

endmodule

// ### atc_timer_monitor.sv
// Concurrent checks on the timer/counter ports
`timescale 1ns/1ns
module atc_timer_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic osc_input_pin,
  input wire logic osc_output_pin,
  input wire logic osc_output_en_n,
  input wire logic [3:0] compare_mode_code,
  input wire logic [15:0] compare_value_pair,
  input wire logic [15:0] timebase_count,
  input wire logic overflow_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic evt;
  // Special event condition on the ports; awready high means no write lands next edge
  assign evt = compare_mode_code == 4'hb && timebase_count == compare_value_pair;
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_evt_clear: assert property (
    evt && s_axi_awready |=> timebase_count == 16'h0000) else $error("no event clear");
  chk_evt_noflag: assert property (
    evt && s_axi_awready && !overflow_irq |=> !overflow_irq) else $error("event set flag");
  chk_wrap_flag: assert property (
    $rose(overflow_irq) && $past(s_axi_awready) |-> $past(timebase_count) == 16'hffff
    && timebase_count == 16'h0000) else $error("flag without wrap");
  chk_flag_sticky: assert property (
    overflow_irq && s_axi_awready |=> overflow_irq) else $error("flag dropped");
  chk_count_step: assert property (
    s_axi_awready && !evt && timebase_count != 16'hffff |=> timebase_count ==
    $past(timebase_count) || timebase_count == $past(timebase_count) + 16'h1)
    else $error("count jumped");
  chk_osc_invert: assert property (
    !osc_output_en_n && $past(osc_output_en_n) == 1'b0 |-> osc_output_pin ==
    !$past(osc_input_pin)) else $error("amplifier wrong");
  cov_overflow: cover property ($rose(overflow_irq));
  cov_event: cover property (evt && s_axi_awready);
  cov_osc: cover property (!osc_output_en_n);
endmodule
bind atc_timer atc_timer_monitor atc_timer_monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .osc_input_pin(osc_input_pin), .osc_output_pin(osc_output_pin),
  .osc_output_en_n(osc_output_en_n), .compare_mode_code(compare_mode_code),
  .compare_value_pair(compare_value_pair), .timebase_count(timebase_count),
  .overflow_irq(overflow_irq));

// ### atc_clk_src.sv
// External edge source and crystal model for the timer/counter
`timescale 1ns/1ns
module atc_clk_src (
  input wire logic aclk,
  input wire logic osc_en_n,
  output logic ext_clk,
  output logic osc_in
);
  logic [2:0] div = 3'h0;
  initial begin
    ext_clk = 1'b0;
  end
  // Crystal swings only while its amplifier is enabled
  always @(posedge aclk) begin
    div <= div + 3'h1;
    if (osc_en_n !== 1'b0) osc_in <= 1'b0;
    else if (div == 3'h7) osc_in <= ~osc_in;
  end
  // Idles low between bursts; four cycles high, five low between pulses
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule

// ### test_async_timer_counter16.sv
// Self-checking bench of the 16-bit timer/counter
`timescale 1ns/1ns
`include "atc_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module test_async_timer_counter16;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_clock_pin, osc_input_pin, osc_output_pin, osc_output_en_n;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, hold, lo_byte;
  logic [3:0] s_axi_wstrb, compare_mode_code;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  logic [15:0] compare_value_pair, timebase_count;
  logic sleep_mode, timebase_valid, overflow_irq;
  int num_errors = 0;
  int cmp_count = 0;
  atc_timer atc_timer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_clock_pin(ext_clock_pin), .osc_input_pin(osc_input_pin),
    .osc_output_pin(osc_output_pin), .osc_output_en_n(osc_output_en_n), .sleep_mode(sleep_mode),
    .compare_mode_code(compare_mode_code), .compare_value_pair(compare_value_pair),
    .timebase_count(timebase_count), .timebase_valid(timebase_valid),
    .overflow_irq(overflow_irq));
  atc_clk_src atc_clk_src_inst (.aclk(aclk), .osc_en_n(osc_output_en_n),
    .ext_clk(ext_clock_pin), .osc_in(osc_input_pin));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rb = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdt(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    summarize();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, sleep_mode, compare_mode_code, compare_value_pair} = 22'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdt(`ATC_OFF_CTRL);
    `CHK(rd, 32'h0)
    rdt(`ATC_OFF_IRQ);
    `CHK(rd, 32'h0)
    `CHK(timebase_valid, 1'b1)
    rdt(32'h10);
    `CHK(rr, `ATC_RESP_SLVERR)
    wr(32'h14, 32'hff);
    `CHK(rb, `ATC_RESP_SLVERR)
    wr(`ATC_OFF_CTRL, 32'hff);
    rdt(`ATC_OFF_CTRL);
    `CHK(rd, 32'h3f)
    `CHK(osc_output_en_n, 1'b0)
    `CHK(timebase_valid, 1'b0)
    wr(`ATC_OFF_CTRL, 32'h0);
    $display("test reset and control done");
    for (int p = 0; p < 4; p++) begin
      wr(`ATC_OFF_CNT_LO, 32'h0);
      wr(`ATC_OFF_CNT_HI, 32'h0);
      wr(`ATC_OFF_CTRL, (p << 4) | 1);
      repeat (256) @(posedge aclk);
      wr(`ATC_OFF_CTRL, 32'h0);
      rdt(`ATC_OFF_CNT_LO);
      `CHK(rd >= (64 >> p) && rd <= (64 >> p) + 2, 1'b1)
    end
    hold = rd;
    repeat (40) @(posedge aclk);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd, hold)
    $display("test prescale done");
    wr(`ATC_OFF_CNT_LO, 32'h0);
    wr(`ATC_OFF_CTRL, 32'h3);
    atc_clk_src_inst.pulses(5);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd, 32'h5)
    sleep_mode <= 1'b1;
    atc_clk_src_inst.pulses(3);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd, 32'h5)
    wr(`ATC_OFF_CTRL, 32'h7);
    atc_clk_src_inst.pulses(3);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd, 32'h8)
    `CHK(timebase_valid, 1'b0)
    sleep_mode <= 1'b0;
    wr(`ATC_OFF_CTRL, 32'h0);
    $display("test external done");
    wr(`ATC_OFF_CNT_HI, 32'hff);
    wr(`ATC_OFF_CNT_LO, 32'hfe);
    wr(`ATC_OFF_IRQ, 32'h2);
    wr(`ATC_OFF_CTRL, 32'h1);
    repeat (20) @(posedge aclk);
    wr(`ATC_OFF_CTRL, 32'h0);
    `CHK(overflow_irq, 1'b1)
    rdt(`ATC_OFF_CNT_HI);
    `CHK(rd, 32'h0)
    wr(`ATC_OFF_IRQ, 32'h2);
    rdt(`ATC_OFF_IRQ);
    `CHK(rd, 32'h3)
    wr(`ATC_OFF_IRQ, 32'h3);
    `CHK(overflow_irq, 1'b0)
    $display("test overflow done");
    compare_value_pair <= 16'h0010;
    compare_mode_code <= `ATC_SPECIAL_MODE;
    wr(`ATC_OFF_CNT_LO, 32'h0);
    wr(`ATC_OFF_CTRL, 32'h1);
    repeat (400) @(posedge aclk);
    wr(`ATC_OFF_CTRL, 32'h0);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd <= 32'h10, 1'b1)
    rdt(`ATC_OFF_IRQ);
    `CHK(rd[0], 1'b0)
    compare_value_pair <= 16'h0000;
    wr(`ATC_OFF_CNT_LO, 32'h0);
    wr(`ATC_OFF_CNT_LO, 32'h33);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd, 32'h33)
    compare_mode_code <= 4'h0;
    $display("test special event done");
    wr(`ATC_OFF_CNT_HI, 32'h12);
    s_axi_wstrb <= 4'he;
    wr(`ATC_OFF_CNT_LO, 32'h77);
    `CHK(rb, `ATC_RESP_OKAY)
    s_axi_wstrb <= 4'hf;
    wr(`ATC_OFF_CTRL, 32'h30);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd, 32'h33)
    rdt(`ATC_OFF_CNT_HI);
    `CHK(rd, 32'h12)
    `CHK(timebase_count, 16'h1233)
    rdt(`ATC_OFF_CTRL);
    `CHK(rd, 32'h0)
    $display("test retention done");
    wr(`ATC_OFF_CTRL, 32'h1);
    wr(`ATC_OFF_CNT_LO, 32'h0);
    wr(`ATC_OFF_CNT_HI, 32'h4);
    wr(`ATC_OFF_CNT_LO, 32'hfe);
    rdt(`ATC_OFF_CNT_HI);
    hold = rd;
    rdt(`ATC_OFF_CNT_LO);
    lo_byte = rd;
    rdt(`ATC_OFF_CNT_HI);
    if (rd !== hold) begin
      rdt(`ATC_OFF_CNT_HI);
      hold = rd;
      rdt(`ATC_OFF_CNT_LO);
      lo_byte = rd;
    end
    hold = {16'h0000, hold[7:0], lo_byte[7:0]};
    `CHK(hold >= 32'h4fe && hold <= 32'h506, 1'b1)
    wr(`ATC_OFF_CTRL, 32'h0);
    wr(`ATC_OFF_CNT_LO, 32'h0);
    wr(`ATC_OFF_CNT_HI, 32'h0);
    $display("test running access done");
    wr(`ATC_OFF_CTRL, 32'h8);
    repeat (64) @(posedge aclk);
    wr(`ATC_OFF_CTRL, 32'hf);
    repeat (160) @(posedge aclk);
    wr(`ATC_OFF_CTRL, 32'h8);
    rdt(`ATC_OFF_CNT_LO);
    `CHK(rd >= 32'h9 && rd <= 32'hc, 1'b1)
    `CHK(osc_output_en_n, 1'b0)
    $display("test crystal done");
    summarize();
  end
endmodule
